// ==== hw/idpd_dev.sv ====
// memory end: identification read, deep power-down entry and resume
`timescale 1ns/1ps
`include "idpd_map.svh"

// Contract
// - opcode 9F then identification bytes out
// - manufacturer byte, then two device bytes
// - fourth byte is zero extension length
// - output released after the length byte
// - chip select high ends read anytime
// - host may stop after device bytes
// - standby when deselected, not busy and not in power-down
// - opcode B9 enters power-down at deselect
// - power-down ignores all but resume
// - short power-down opcode is abandoned
// - reset starts in standby
// - power-down ignored while busy
// - opcode AB resumes standby at deselect
// - short resume opcode keeps power-down
// - after resume normal commands accepted
// - mode change within three microseconds
module idpd_dev #(
	parameter logic [7:0] MANUF_ID = 8'hA5,
	parameter logic [2:0] FAMILY_CODE = 3'h5,
	parameter logic [4:0] DENSITY_CODE = 5'h0B,
	parameter logic [2:0] CELL_CODE = 3'h3,
	parameter logic [4:0] VERSION_CODE = 5'h01
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// serial link
	idpd_if.dev link,
	// internal operation status
	input wire logic busy_i,
	// mode status
	output logic dpd_o,
	output logic standby_o,
	// opcodes handed on to the rest of the command logic
	output logic op_valid_o,
	output idpd_pkg::idpd_op_t op_o
);

	// identification codes above are arbitrary neutral values
	localparam logic [31:0] ID_WORD = {MANUF_ID, FAMILY_CODE, DENSITY_CODE,
		CELL_CODE, VERSION_CODE, `IDPD_EXT_LEN};

	// mode change must fit inside the documented longest delays
	generate
		if (`IDPD_DEV_MODE_LATENCY > `IDPD_POWER_DOWN_ENTRY_DELAY_CYC ||
			`IDPD_DEV_MODE_LATENCY > `IDPD_POWER_DOWN_EXIT_DELAY_CYC) begin : g_chk
			$error("idpd_dev: mode latency exceeds power-down delay");
		end
	endgenerate

	// ----------------------------------------
	// input synchronisers
	// ----------------------------------------
	logic cs_n_q1;
	logic cs_n_s;
	logic cs_n_prev;
	logic sck_q1;
	logic sck_s;
	logic sck_prev;
	logic si_q1;
	logic si_s;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cs_n_q1 <= 1'b1;
			cs_n_s <= 1'b1;
			cs_n_prev <= 1'b1;
			sck_q1 <= 1'b0;
			sck_s <= 1'b0;
			sck_prev <= 1'b0;
			si_q1 <= 1'b0;
			si_s <= 1'b0;
		end else begin
			cs_n_q1 <= link.cs_n;
			cs_n_s <= cs_n_q1;
			cs_n_prev <= cs_n_s;
			sck_q1 <= link.sck;
			sck_s <= sck_q1;
			sck_prev <= sck_s;
			si_q1 <= link.si;
			si_s <= si_q1;
		end
	end

	logic active;
	logic sck_rise;
	logic sck_fall;
	logic cs_end;
	assign active = ~cs_n_s;
	// edges only count inside a frame, so a mode 3 idle-high clock is harmless
	assign sck_rise = active & sck_s & ~sck_prev;
	assign sck_fall = active & ~sck_s & sck_prev;
	assign cs_end = cs_n_s & ~cs_n_prev;

	// ----------------------------------------
	// opcode shifter and command decode
	// ----------------------------------------
	idpd_pkg::idpd_dev_state_e state;
	logic [2:0] bit_cnt;
	logic [6:0] shreg;
	logic [5:0] out_cnt;
	logic pd_armed;
	logic resume_armed;
	logic dpd;
	idpd_pkg::idpd_op_t next_op;

	assign next_op = {shreg, si_s};

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state <= idpd_pkg::DEV_OPCODE;
			bit_cnt <= 3'h0;
			shreg <= 7'h00;
		end else if (!active) begin
			state <= idpd_pkg::DEV_OPCODE;
			bit_cnt <= 3'h0;
		end else begin
			case (state)
				idpd_pkg::DEV_OPCODE: begin
					if (sck_rise) begin
						shreg <= next_op[6:0];
						bit_cnt <= bit_cnt + 3'h1;
						if (bit_cnt == 3'h7) begin
							if (!dpd && next_op == `IDPD_OP_READ_ID) begin
								state <= idpd_pkg::DEV_ID_OUT;
							end else begin
								state <= idpd_pkg::DEV_IGNORE;
							end
						end
					end
				end
				idpd_pkg::DEV_ID_OUT: begin
					if (sck_fall && out_cnt == 6'(`IDPD_ID_BITS)) begin
						state <= idpd_pkg::DEV_IGNORE;
					end
				end
				default: begin
					state <= idpd_pkg::DEV_IGNORE;
				end
			endcase
		end
	end

	logic opcode_done;
	assign opcode_done = active && state == idpd_pkg::DEV_OPCODE && sck_rise && bit_cnt == 3'h7;

	// arming happens at the last opcode bit; the mode changes only at deselect
	always_ff @(posedge clk_i) begin
		if (rst_i || cs_end) begin
			pd_armed <= 1'b0;
			resume_armed <= 1'b0;
		end else if (opcode_done) begin
			pd_armed <= !dpd && !busy_i && next_op == `IDPD_OP_POWER_DOWN;
			resume_armed <= dpd && next_op == `IDPD_OP_RESUME;
		end
	end

	// ----------------------------------------
	// power mode
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dpd <= 1'b0;
		end else if (cs_end) begin
			// change one cycle after deselect seen
			if (pd_armed) begin
				dpd <= 1'b1;
			end else if (resume_armed) begin
				dpd <= 1'b0;
			end
		end
	end

	// other opcodes pass on only out of power-down
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			op_valid_o <= 1'b0;
			op_o <= 8'h00;
		end else begin
			op_valid_o <= opcode_done && !dpd && next_op != `IDPD_OP_READ_ID &&
				next_op != `IDPD_OP_POWER_DOWN && next_op != `IDPD_OP_RESUME;
			if (opcode_done && !dpd) begin
				op_o <= next_op;
			end
		end
	end

	// ----------------------------------------
	// identification output
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i || !active || state != idpd_pkg::DEV_ID_OUT) begin
			out_cnt <= 6'h00;
			link.so_oe <= 1'b0;
			link.so_d <= 1'b0;
		end else if (sck_fall) begin
			if (out_cnt == 6'(`IDPD_ID_BITS)) begin
				// no data after the length byte
				link.so_oe <= 1'b0;
			end else begin
				link.so_oe <= 1'b1;
				link.so_d <= ID_WORD[5'(`IDPD_ID_BITS - 1) - out_cnt[4:0]];
				out_cnt <= out_cnt + 6'h01;
			end
		end
	end

	// ----------------------------------------
	// status
	// ----------------------------------------
	assign dpd_o = dpd;
	assign standby_o = cs_n_s & ~dpd & ~busy_i;

endmodule // idpd_dev

// ==== hw/idpd_host.sv ====
// host end: frames opcodes, makes the serial clock and collects the reply
`timescale 1ns/1ps
`include "idpd_map.svh"

module idpd_host #(
	parameter int SCK_HALF = `IDPD_SCK_HALF,
	parameter int WAIT_CYC = `IDPD_HOST_WAIT_CYC
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// serial link
	idpd_if.host link,
	// request
	input wire logic req_valid_i,
	output logic req_ready_o,
	input wire idpd_pkg::idpd_op_t req_op_i,
	input wire logic [3:0] req_bits_i,
	input wire logic [2:0] req_bytes_i,
	// answer
	output logic done_o,
	output logic [31:0] rx_o
);

	// the reply is sampled at the end of the high phase; shorter halves lose it
	generate
		if (SCK_HALF < `IDPD_SCK_HALF_MIN || SCK_HALF > 255 || WAIT_CYC < 1 ||
			WAIT_CYC > 65535) begin : g_chk
			$error("idpd_host: unsupported SCK_HALF or WAIT_CYC");
		end
	endgenerate

	// ----------------------------------------
	// reply synchroniser
	// ----------------------------------------
	logic so_q1;
	logic so_s;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			so_q1 <= 1'b0;
			so_s <= 1'b0;
		end else begin
			so_q1 <= link.so;
			so_s <= so_q1;
		end
	end

	// ----------------------------------------
	// frame sequencer
	// ----------------------------------------
	idpd_pkg::idpd_host_state_e state;
	logic [7:0] div_cnt;
	logic [15:0] gap_cnt;
	logic [5:0] bit_cnt;
	logic [5:0] total;
	logic [3:0] op_bits;
	logic [7:0] op_sh;
	logic tick;

	assign tick = div_cnt == 8'(SCK_HALF - 1);
	assign req_ready_o = state == idpd_pkg::HOST_IDLE;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state <= idpd_pkg::HOST_IDLE;
			link.cs_n <= 1'b1;
			link.sck <= 1'b0;
			link.si <= 1'b0;
			div_cnt <= 8'h00;
			gap_cnt <= 16'h0000;
			bit_cnt <= 6'h00;
			total <= 6'h00;
			op_bits <= 4'h0;
			op_sh <= 8'h00;
			rx_o <= 32'h0000_0000;
			done_o <= 1'b0;
		end else begin
			done_o <= 1'b0;
			case (state)
				idpd_pkg::HOST_IDLE: begin
					if (req_valid_i && req_bits_i != 4'h0) begin
						// host picks how many bytes to read
						link.cs_n <= 1'b0;
						link.si <= req_op_i[7];
						op_sh <= {req_op_i[6:0], 1'b0};
						op_bits <= (req_bits_i > 4'h8) ? 4'h8 : req_bits_i;
						total <= (req_bits_i >= 4'h8) ?
							6'(`IDPD_OP_BITS) + {req_bytes_i, 3'h0} : {2'h0, req_bits_i};
						bit_cnt <= 6'h00;
						div_cnt <= 8'h00;
						rx_o <= 32'h0000_0000;
						state <= idpd_pkg::HOST_SHIFT;
					end
				end
				idpd_pkg::HOST_SHIFT: begin
					div_cnt <= tick ? 8'h00 : div_cnt + 8'h01;
					if (tick) begin
						if (!link.sck) begin
							link.sck <= 1'b1;
						end else begin
							link.sck <= 1'b0;
							bit_cnt <= bit_cnt + 6'h01;
							if (bit_cnt >= {2'h0, op_bits}) begin
								rx_o <= {rx_o[30:0], so_s};
							end
							if (bit_cnt + 6'h01 == total) begin
								link.cs_n <= 1'b1;
								gap_cnt <= 16'h0000;
								state <= idpd_pkg::HOST_GAP;
							end else begin
								link.si <= op_sh[7];
								op_sh <= {op_sh[6:0], 1'b0};
							end
						end
					end
				end
				default: begin
					// hold off for the mode change delay
					gap_cnt <= gap_cnt + 16'h0001;
					if (gap_cnt == 16'(WAIT_CYC - 1)) begin
						done_o <= 1'b1;
						state <= idpd_pkg::HOST_IDLE;
					end
				end
			endcase
		end
	end

endmodule // idpd_host

// ==== hw/idpd_if.sv ====
// serial link between the host controller and the memory's command slice
`timescale 1ns/1ps
interface idpd_if;
	logic cs_n;
	logic sck;
	logic si;
	logic so_d;
	logic so_oe;
	wire so;

	// the device is the only driver; a released line reads high, as through a pull-up
	assign so = so_oe ? so_d : 1'b1;

	modport dev (
		input cs_n,
		input sck,
		input si,
		output so_d,
		output so_oe
	);

	modport host (
		output cs_n,
		output sck,
		output si,
		input so
	);
endinterface

// ==== hw/idpd_map.svh ====
// constants for the identification read and power-down command slice
`ifndef IDPD_MAP_SVH
`define IDPD_MAP_SVH

// ----------------------------------------
// opcodes
// ----------------------------------------
`define IDPD_OP_READ_ID 8'h9F
`define IDPD_OP_POWER_DOWN 8'hB9
`define IDPD_OP_RESUME 8'hAB
`define IDPD_OP_BITS 8

// ----------------------------------------
// identification response layout
// ----------------------------------------
`define IDPD_ID_BYTES 4
`define IDPD_ID_BITS 32
`define IDPD_EXT_LEN 8'h00

// ----------------------------------------
// timing
// ----------------------------------------
`define IDPD_CLK_PERIOD_NS 50
`define IDPD_POWER_DOWN_ENTRY_DELAY_NS 3000
`define IDPD_POWER_DOWN_EXIT_DELAY_NS 3000
// longest times round down
`define IDPD_POWER_DOWN_ENTRY_DELAY_CYC (`IDPD_POWER_DOWN_ENTRY_DELAY_NS / `IDPD_CLK_PERIOD_NS)
`define IDPD_POWER_DOWN_EXIT_DELAY_CYC (`IDPD_POWER_DOWN_EXIT_DELAY_NS / `IDPD_CLK_PERIOD_NS)
// the host's wait is a least time, so it rounds up
`define IDPD_HOST_WAIT_CYC ((`IDPD_POWER_DOWN_ENTRY_DELAY_NS + `IDPD_CLK_PERIOD_NS - 1) / `IDPD_CLK_PERIOD_NS)
// cycles of clk per serial clock half period made by the host
`define IDPD_SCK_HALF 4
// least half period that the sampled round trip allows
`define IDPD_SCK_HALF_MIN 4
// device latency from chip select high to mode change, in clk cycles
`define IDPD_DEV_MODE_LATENCY 4

`endif

// ==== hw/idpd_pkg.sv ====
// types shared by both ends of the identification and power-down link
package idpd_pkg;

	typedef logic [7:0] idpd_op_t;

	typedef enum logic [1:0] {
		DEV_OPCODE,
		DEV_ID_OUT,
		DEV_IGNORE
	} idpd_dev_state_e;

	typedef enum logic [1:0] {
		HOST_IDLE,
		HOST_SHIFT,
		HOST_GAP
	} idpd_host_state_e;

endpackage

// ==== verif/idpd_assertions.sv ====
// checker for the serial link between host and memory slice
`timescale 1ns/1ps
module idpd_checker (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// link and mode
	input wire logic cs_n,
	input wire logic sck,
	input wire logic si,
	input wire logic so_d,
	input wire logic so_oe,
	input wire logic dpd_o
);
	logic sck_q;
	logic [6:0] rises;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	always_ff @(posedge clk_i) begin
		sck_q <= sck;
	end
	// saturates so that a long frame cannot wrap back into the reply window
	always_ff @(posedge clk_i) begin
		if (rst_i || cs_n) begin
			rises <= 7'h00;
		end else if (sck && !sck_q && rises != 7'h7F) begin
			rises <= rises + 7'h01;
		end
	end
	// ----------------------------------------
	// link assertions
	// ----------------------------------------
	AST_RESET_STANDBY: assert property ($past(rst_i) |-> !dpd_o && !so_oe)
		else $error("mode or output active after reset");
	AST_SO_START: assert property ($rose(so_oe) |-> rises == 7'h08)
		else $error("output enabled at wrong bit");
	AST_SO_MAX: assert property (!cs_n && so_oe |-> rises <= 7'h28)
		else $error("output driven past length byte");
	AST_LEN_ZERO: assert property (!cs_n && so_oe && rises >= 7'h21 |-> !so_d)
		else $error("length byte not zero");
	AST_IDLE_SO: assert property (cs_n [*6] |-> !so_oe)
		else $error("output driven while deselected");
	AST_DPD_QUIET: assert property (dpd_o |-> !so_oe)
		else $error("output driven in power-down");
	AST_DPD_AT_DESELECT: assert property ($changed(dpd_o) |-> cs_n && $past(cs_n, 2))
		else $error("mode changed while selected");
	AST_SO_ON_FALL: assert property ($changed(so_d) || $rose(so_oe) |-> !sck)
		else $error("output changed in clock high phase");
	AST_SI_ON_FALL: assert property (!cs_n && sck |-> $stable(si))
		else $error("host data changed in clock high phase");
endmodule // idpd_checker

// ==== verif/tb_top.sv ====
// self-checking bench for both ends of the link
`timescale 1ns/1ps
module tb_top;
	// arbitrary identification values
	localparam logic [31:0] ID = {8'h3C, 3'h3, 5'h11, 3'h6, 5'h04, 8'h00};
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic busy = 1'b0;
	logic req_valid = 1'b0;
	logic [7:0] req_op = 8'h00;
	logic [3:0] req_bits = 4'h8;
	logic [2:0] req_bytes = 3'h0;
	logic req_ready, done, dpd, standby, op_valid;
	logic [7:0] op;
	logic [31:0] rx;
	int fail_count = 0;
	int tests_run = 0;
	int pulses = 0;
	int k;
	int p;
	logic [7:0] r;
	idpd_if link_if ();
	idpd_dev #(.MANUF_ID(ID[31:24]), .FAMILY_CODE(ID[23:21]), .DENSITY_CODE(ID[20:16]),
		.CELL_CODE(ID[15:13]), .VERSION_CODE(ID[12:8])) idpd_dev_inst (.clk_i(clk_i),
		.rst_i(rst_i), .link(link_if.dev), .busy_i(busy), .dpd_o(dpd),
		.standby_o(standby), .op_valid_o(op_valid), .op_o(op));
	idpd_host #(.SCK_HALF(6)) idpd_host_inst (.clk_i(clk_i), .rst_i(rst_i),
		.link(link_if.host), .req_valid_i(req_valid), .req_ready_o(req_ready),
		.req_op_i(req_op), .req_bits_i(req_bits), .req_bytes_i(req_bytes),
		.done_o(done), .rx_o(rx));
	idpd_checker idpd_checker_inst (.clk_i(clk_i), .rst_i(rst_i), .cs_n(link_if.cs_n),
		.sck(link_if.sck), .si(link_if.si), .so_d(link_if.so_d), .so_oe(link_if.so_oe),
		.dpd_o(dpd));
	initial begin
		forever #25 clk_i = ~clk_i;
	end
	always @(posedge clk_i) begin
		if (op_valid === 1'b1) pulses <= pulses + 1;
	end
	function automatic logic [31:0] id_top(input int n);
		return ID >> (32 - 8 * n);
	endfunction
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	// one frame: request taken at the next rising edge, then bounded wait for done
	task automatic send(input logic [7:0] o, input int b, input int n);
		int t;
		@(negedge clk_i);
		req_op = o;
		req_bits = 4'(b);
		req_bytes = 3'(n);
		req_valid = 1'b1;
		@(negedge clk_i);
		req_valid = 1'b0;
		t = 0;
		while (done !== 1'b1) begin
			@(negedge clk_i);
			t++;
			if (t > 3000) begin
				check("done within limit", 1, done);
				stop_test();
			end
		end
		check("ready after done", 1, req_ready);
	endtask
	initial begin
		void'($urandom(76315));
		repeat (10) @(negedge clk_i);
		rst_i = 1'b0;
		check("dpd after reset", 0, dpd);
		check("standby idle", 1, standby);
		send(8'h9F, 8, 4);
		check("full id", ID, rx);
		send(8'h9F, 8, 5);
		check("id past length", ID[23:0], rx[31:8]);
		check("released after length", 8'hFF, rx[7:0]);
		for (k = 0; k < 6; k++) begin
			p = $urandom_range(4, 1);
			send(8'h9F, 8, p);
			check("partial id", id_top(p), rx);
			r = 8'($urandom);
			if (r inside {8'h9F, 8'hB9, 8'hAB}) r = 8'h05;
			send(r, 8, $urandom_range(2, 0));
			check("other opcode", r, op);
		end
		check("opcode pulses", 6, pulses);
		for (k = 1; k < 8; k++) begin
			send(8'hB9, k, 0);
			check("short entry", 0, dpd);
		end
		busy = 1'b1;
		send(8'hB9, 8, 0);
		check("entry while busy", 0, dpd);
		check("standby busy", 0, standby);
		busy = 1'b0;
		send(8'hB9, 8, $urandom_range(3, 0));
		check("entry", 1, dpd);
		p = pulses;
		send(8'h9F, 8, 1);
		check("id in dpd", 32'h0000_00FF, rx);
		send(8'h42, 8, 0);
		send(8'hB9, 8, 0);
		check("ignored in dpd", p, pulses);
		for (k = 1; k < 8; k++) begin
			send(8'hAB, k, 0);
			check("short resume", 1, dpd);
		end
		send(8'hAB, 8, $urandom_range(3, 0));
		check("resume", 0, dpd);
		send(8'h9F, 8, 4);
		check("id after resume", ID, rx);
		send(8'hB9, 8, 0);
		check("entry again", 1, dpd);
		@(negedge clk_i);
		rst_i = 1'b1;
		repeat (3) @(negedge clk_i);
		rst_i = 1'b0;
		check("dpd after second reset", 0, dpd);
		send(8'h9F, 8, 4);
		check("id after second reset", ID, rx);
		stop_test();
	end
endmodule // tb_top
